// ### rtl/mlsf_map.svh
// register offsets, field positions and fixed values of the limit status flags
`ifndef MLSF_MAP_SVH
`define MLSF_MAP_SVH

// register offsets
`define MLSF_OFF_VOLT_TEMP_STATUS   8'h41
`define MLSF_OFF_FAN_FAULT_STATUS   8'h42
`define MLSF_OFF_VOLTAGE_ID_PINS    8'h43

// reset values of the two status registers
`define MLSF_STATUS_RESET           8'h00

// voltage_temp_status fields
`define MLSF_S1_PENDING_BIT         7
// fan_and_fault_status fields
`define MLSF_S2_VOLT12_BIT          0
`define MLSF_S2_RESERVED_BIT        1
`define MLSF_S2_TACH_LSB            2
`define MLSF_S2_FAULT_ONE_BIT       6
`define MLSF_S2_FAULT_TWO_BIT       7

// reading forced into a faulty remote diode
`define MLSF_FORCED_TEMP            8'h80

// channel counts and id pin width
`define MLSF_NUM_VOLT               5
`define MLSF_NUM_TEMP               3
`define MLSF_NUM_TACH               4
`define MLSF_NUM_CH                 12
`define MLSF_VID_WIDTH              5

`endif

// ### rtl/mlsf_pkg.sv
// types shared by the limit status flag logic
`default_nettype none

package mlsf_pkg;

  typedef logic [7:0] mlsf_byte_type;

  // limit channel index: volt 2.5/core/main/5V/12V, temp remote one/internal/remote two, fans
  typedef enum logic [3:0]
  {
    CH_V25, CH_VCORE, CH_VMAIN, CH_V5, CH_V12,
    CH_REM_ONE, CH_INTERNAL, CH_REM_TWO,
    CH_FAN_ONE, CH_FAN_TWO, CH_FAN_THREE, CH_FAN_FOUR
  } mlsf_chan_type;

endpackage

`default_nettype wire

// ### rtl/mlsf_cmp.sv
// limit comparator: window check or tachometer minimum check
`timescale 1ns/1ns
`default_nettype none

module mlsf_cmp
#(
  parameter int WIDTH = 17
)
(
  // operands, all signed
  input  wire logic [WIDTH-1:0] reading,
  input  wire logic [WIDTH-1:0] lo_limit,
  input  wire logic [WIDTH-1:0] hi_limit,
  // 1: only the upper bound counts
  input  wire logic             min_mode,
  // result
  output logic                  violate
);

  wire lo_hit;
  wire hi_hit;

  // low limit is inclusive, high limit exclusive
  assign lo_hit  = $signed(reading) <= $signed(lo_limit);
  assign hi_hit  = $signed(reading) >  $signed(hi_limit);
  assign violate = hi_hit | (lo_hit & ~min_mode);

endmodule // mlsf_cmp

`default_nettype wire

// ### rtl/mlsf_top.sv
// status flag logic of the hardware monitor: limit checks, sticky bits, fault bits, id pins
`timescale 1ns/1ns
`default_nettype none
`include "mlsf_map.svh"

module mlsf_top
#(
  parameter int NUM_TACH = `MLSF_NUM_TACH
)
(
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         arst_n,
  // register port
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_rd,
  output logic [7:0]                        reg_rdata_r,
  // monitoring control
  input  wire logic                         monitor_start,
  // individual enables
  input  wire logic [`MLSF_NUM_VOLT-1:0]    volt_en,
  input  wire logic [`MLSF_NUM_TEMP-1:0]    temp_en,
  input  wire logic [NUM_TACH-1:0]          fan_en,
  // voltage readings and limits
  input  wire logic [`MLSF_NUM_VOLT-1:0]    volt_upd,
  input  wire logic [`MLSF_NUM_VOLT-1:0][7:0] volt_reading,
  input  wire logic [`MLSF_NUM_VOLT-1:0][7:0] volt_low_limit,
  input  wire logic [`MLSF_NUM_VOLT-1:0][7:0] volt_high_limit,
  // temperature readings and limits, two's complement
  input  wire logic [`MLSF_NUM_TEMP-1:0]    temp_upd,
  input  wire logic [`MLSF_NUM_TEMP-1:0][7:0] temp_reading,
  input  wire logic [`MLSF_NUM_TEMP-1:0][7:0] temp_low_limit,
  input  wire logic [`MLSF_NUM_TEMP-1:0][7:0] temp_high_limit,
  // tachometer readings and minimums
  input  wire logic [NUM_TACH-1:0]          tach_upd,
  input  wire logic [NUM_TACH-1:0][15:0]    tach_reading,
  input  wire logic [NUM_TACH-1:0][15:0]    tach_min,
  // diode pin pair fault detectors, one and two
  input  wire logic [1:0]                   diode_fault,
  // voltage identification pins
  input  wire logic [`MLSF_VID_WIDTH-1:0]   voltage_ident_pins,
  // forced-aware diode reading registers
  output mlsf_pkg::mlsf_byte_type           remote_one_reading_r,
  output mlsf_pkg::mlsf_byte_type           remote_two_reading_r
);

  localparam int NCH     = `MLSF_NUM_VOLT + `MLSF_NUM_TEMP + NUM_TACH;
  localparam int TB      = `MLSF_NUM_VOLT + `MLSF_NUM_TEMP;
  localparam int DIO_ONE = int'(mlsf_pkg::CH_REM_ONE);
  localparam int DIO_TWO = int'(mlsf_pkg::CH_REM_TWO);

  // per-channel operands and controls
  logic [16:0]    ch_rd [NCH];
  logic [16:0]    ch_lo [NCH];
  logic [16:0]    ch_hi [NCH];
  logic [NCH-1:0] ch_min;
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] ch_upd;
  logic [NCH-1:0] ch_kill;
  logic [NCH-1:0] ch_rdclr;
  logic [NCH-1:0] ch_viol;

  // sticky bits and the condition seen at the last update
  logic [NCH-1:0] lim_stat_r;
  logic [NCH-1:0] lim_stat_nxt;
  logic [NCH-1:0] lim_act_r;
  logic [NCH-1:0] lim_act_nxt;
  logic [1:0]     flt_stat_r;
  logic [1:0]     flt_stat_nxt;

  mlsf_pkg::mlsf_byte_type status1_w;
  mlsf_pkg::mlsf_byte_type status2_w;
  mlsf_pkg::mlsf_byte_type rdata_nxt;

  wire rd_s1;
  wire rd_s2;
  wire rd_vid;
  wire [1:0] diode_en;
  wire [1:0] fault_force;

  // register decode; no write path exists, so writes cannot alter anything
  assign rd_s1  = reg_rd & (reg_addr == `MLSF_OFF_VOLT_TEMP_STATUS);
  assign rd_s2  = reg_rd & (reg_addr == `MLSF_OFF_FAN_FAULT_STATUS);
  assign rd_vid = reg_rd & (reg_addr == `MLSF_OFF_VOLTAGE_ID_PINS);

  assign diode_en    = {temp_en[2], temp_en[0]};
  // fault loads 80h every cycle it lasts while started
  assign fault_force = diode_fault & {2{monitor_start}};

  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
      if (i < `MLSF_NUM_VOLT)
      begin : g_volt
        assign ch_rd[i]    = {9'h000, volt_reading[i]};
        assign ch_lo[i]    = {9'h000, volt_low_limit[i]};
        assign ch_hi[i]    = {9'h000, volt_high_limit[i]};
        assign ch_min[i]   = 1'b0;
        assign ch_en[i]    = volt_en[i];
        // updates only while started
        assign ch_upd[i]   = volt_upd[i] & monitor_start;
        assign ch_kill[i]  = 1'b0;
      end
      else if (i < TB)
      begin : g_temp
        localparam int K = i - `MLSF_NUM_VOLT;
        localparam int F = (K == 0) ? 0 : 1;
        localparam bit IS_DIODE = (i == DIO_ONE) || (i == DIO_TWO);
        wire forced;
        assign forced      = IS_DIODE & fault_force[F];
        // signed compare via sign extension
        assign ch_rd[i]    = forced ? {9'h1FF, `MLSF_FORCED_TEMP}
                                    : {{9{temp_reading[K][7]}}, temp_reading[K]};
        assign ch_lo[i]    = {{9{temp_low_limit[K][7]}}, temp_low_limit[K]};
        assign ch_hi[i]    = {{9{temp_high_limit[K][7]}}, temp_high_limit[K]};
        assign ch_min[i]   = 1'b0;
        assign ch_en[i]    = temp_en[K];
        assign ch_upd[i]   = (temp_upd[K] & monitor_start) | forced;
        // diode disable clears at once, not at the next update
        assign ch_kill[i]  = IS_DIODE & ~temp_en[K];
      end
      else
      begin : g_tach
        localparam int K = i - TB;
        assign ch_rd[i]    = {1'b0, tach_reading[K]};
        assign ch_lo[i]    = 17'h00000;
        assign ch_hi[i]    = {1'b0, tach_min[K]};
        // only exceeding the minimum counts
        assign ch_min[i]   = 1'b1;
        assign ch_en[i]    = fan_en[K];
        assign ch_upd[i]   = tach_upd[K] & monitor_start;
        assign ch_kill[i]  = 1'b0;
      end

      if ((i == int'(mlsf_pkg::CH_V12)) || (i >= TB))
      begin : g_in_s2
        assign ch_rdclr[i] = rd_s2;
      end
      else
      begin : g_in_s1
        assign ch_rdclr[i] = rd_s1;
      end

      mlsf_cmp #(.WIDTH(17)) u_cmp
      (
        .reading  (ch_rd[i]),
        .lo_limit (ch_lo[i]),
        .hi_limit (ch_hi[i]),
        .min_mode (ch_min[i]),
        .violate  (ch_viol[i])
      );

      // condition tracked per update
      assign lim_act_nxt[i]  = ch_upd[i] ? (ch_viol[i] & ch_en[i]) : lim_act_r[i];
      // kill, then set (wins over read), then disabled update clears, then read
      assign lim_stat_nxt[i] = ch_kill[i]                          ? 1'b0 :
                               (ch_upd[i] & ch_en[i] & ch_viol[i]) ? 1'b1 :
                               (ch_upd[i] & ~ch_en[i])             ? 1'b0 :
                               ch_rdclr[i] ? (lim_stat_r[i] & lim_act_nxt[i])
                                           : lim_stat_r[i];
    end
  endgenerate

  // fault bits: no rise when stopped or disabled; read keeps a live fault
  // a disabled diode holds no fault bit at all
  assign flt_stat_nxt = diode_en & (
                          (fault_force & diode_en)
                        | (flt_stat_r & ~({2{rd_s2}} & ~diode_fault))
                        );

  // group enables are not inputs here; only individual ones gate setting
  assign status2_w = {flt_stat_r[1], flt_stat_r[0], lim_stat_r[TB+3 -: 4], 1'b0,
                      lim_stat_r[int'(mlsf_pkg::CH_V12)]};
  // pending bit follows status-2 both ways
  assign status1_w = {(|status2_w), lim_stat_r[DIO_TWO:DIO_ONE], lim_stat_r[3:0]};

  // id pins sampled at the read; unmapped offsets leave the answer unchanged
  assign rdata_nxt = rd_s1  ? status1_w :
                     rd_s2  ? status2_w :
                     rd_vid ? {3'h0, voltage_ident_pins} :
                     reg_rdata_r;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lim_stat_r <= '0;
      lim_act_r  <= '0;
      flt_stat_r <= 2'h0;
    end
    else
    begin
      lim_stat_r <= lim_stat_nxt;
      lim_act_r  <= lim_act_nxt;
      flt_stat_r <= flt_stat_nxt;
    end
  end

  // answer holds until the next read; it carries the pre-clear value
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_r <= `MLSF_STATUS_RESET;
    else
      reg_rdata_r <= rdata_nxt;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      remote_one_reading_r <= 8'h00;
      remote_two_reading_r <= 8'h00;
    end
    else
    begin
      if (ch_upd[DIO_ONE])
        remote_one_reading_r <= ch_rd[DIO_ONE][7:0];
      if (ch_upd[DIO_TWO])
        remote_two_reading_r <= ch_rd[DIO_TWO][7:0];
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_VOLT_WINDOW: assert property (
    (ch_upd[0] && volt_en[0] && volt_reading[0] <= volt_low_limit[0])
      |=> lim_stat_r[0])
    else $error("2.5V low violation did not set its bit");

  AST_TEMP_SIGNED: assert property (
    (ch_upd[int'(mlsf_pkg::CH_INTERNAL)] && temp_en[1]
      && $signed(temp_reading[1]) > $signed(temp_high_limit[1]))
      |=> lim_stat_r[int'(mlsf_pkg::CH_INTERNAL)])
    else $error("internal sensor high violation did not set its bit");

  AST_PENDING: assert property (
    rd_s1 |=> reg_rdata_r[`MLSF_S1_PENDING_BIT] == (|$past(status2_w)))
    else $error("pending bit does not mirror status-2");

  AST_RESERVED_ZERO: assert property (
    rd_s2 |=> !reg_rdata_r[`MLSF_S2_RESERVED_BIT])
    else $error("reserved status-2 bit read as one");

  AST_TACH_SLOW: assert property (
    (tach_upd[0] && monitor_start && fan_en[0] && tach_reading[0] > tach_min[0])
      ##1 rd_s2 |=> reg_rdata_r[`MLSF_S2_TACH_LSB])
    else $error("slow fan one not reported");

  AST_FAULT_FORCE: assert property (
    (monitor_start && diode_fault[0] && temp_en[0])
      |=> flt_stat_r[0] && lim_stat_r[DIO_ONE] && remote_one_reading_r == `MLSF_FORCED_TEMP)
    else $error("diode one fault did not force 80h and set both bits");

  AST_FAULT_STICKY: assert property (
    (flt_stat_r[1] && diode_fault[1] && temp_en[2]) |=> flt_stat_r[1])
    else $error("live diode two fault bit was cleared");

  AST_DIODE_DISABLE: assert property (
    !temp_en[2] |=> !flt_stat_r[1] && !lim_stat_r[DIO_TWO])
    else $error("disabled diode two kept a bit");

  AST_READ_CLEAR: assert property (
    (rd_s1 && !ch_upd[0] && !lim_act_r[0]) |=> !lim_stat_r[0])
    else $error("inactive bit survived a read");

  AST_HOLD: assert property (
    (lim_stat_r[3] && !rd_s1 && !ch_upd[3]) |=> lim_stat_r[3])
    else $error("status bit dropped without read or update");

  AST_NO_RISE_DISABLED: assert property (
    1'b1 |=> (lim_stat_r & ~$past(lim_stat_r) & ~$past(ch_en)) == '0)
    else $error("status bit rose while its enable was cleared");

  AST_DISABLED_UPDATE: assert property (
    (ch_upd[4] && !volt_en[4]) |=> !lim_stat_r[4])
    else $error("disabled 12V bit not cleared on update");

  AST_VID: assert property (
    rd_vid |=> reg_rdata_r == {3'h0, $past(voltage_ident_pins)})
    else $error("id register does not show the pins");

  AST_STOPPED: assert property (
    !monitor_start |=> (lim_stat_r & ~$past(lim_stat_r)) == '0
                       && (flt_stat_r & ~$past(flt_stat_r)) == 2'h0)
    else $error("status bit set while monitoring stopped");

  AST_READ_VALUE: assert property (
    rd_s1 |=> reg_rdata_r == $past(status1_w))
    else $error("read did not return the pre-clear value");

  COV_VOLT_SET_READ: cover property (
    (ch_upd[1] && ch_en[1] && ch_viol[1]) ##1 rd_s1 ##1 reg_rdata_r[1]);
  COV_FAULT: cover property (
    (monitor_start && diode_fault[1] && temp_en[2]) ##1 rd_s2 ##1 reg_rdata_r[7]);
  COV_TACH_CLEAR: cover property (
    lim_stat_r[TB] && !lim_act_r[TB] && rd_s2 ##1 !lim_stat_r[TB]);
  COV_PENDING: cover property (rd_s1 ##1 reg_rdata_r[`MLSF_S1_PENDING_BIT]);

endmodule // mlsf_top

`default_nettype wire

// ### test/mlsf_tb.sv
// self-checking testbench of the limit status flag logic with a behavioural model
`timescale 1ns/1ns
`default_nettype none
`include "mlsf_map.svh"

module testbench;
  logic                              sys_clk;
  logic                              arst_n;
  logic [7:0]                        reg_addr;
  logic                              reg_rd;
  logic [7:0]                        reg_rdata_r;
  logic                              monitor_start;
  logic [`MLSF_NUM_VOLT-1:0]         volt_en;
  logic [`MLSF_NUM_TEMP-1:0]         temp_en;
  logic [3:0]                        fan_en;
  logic [`MLSF_NUM_VOLT-1:0]         volt_upd;
  logic [`MLSF_NUM_VOLT-1:0][7:0]    volt_reading;
  logic [`MLSF_NUM_VOLT-1:0][7:0]    volt_low_limit;
  logic [`MLSF_NUM_VOLT-1:0][7:0]    volt_high_limit;
  logic [`MLSF_NUM_TEMP-1:0]         temp_upd;
  logic [`MLSF_NUM_TEMP-1:0][7:0]    temp_reading;
  logic [`MLSF_NUM_TEMP-1:0][7:0]    temp_low_limit;
  logic [`MLSF_NUM_TEMP-1:0][7:0]    temp_high_limit;
  logic [3:0]                        tach_upd;
  logic [3:0][15:0]                  tach_reading;
  logic [3:0][15:0]                  tach_min;
  logic [1:0]                        diode_fault;
  logic [`MLSF_VID_WIDTH-1:0]        voltage_ident_pins;
  mlsf_pkg::mlsf_byte_type           remote_one_reading_r;
  mlsf_pkg::mlsf_byte_type           remote_two_reading_r;
  int                                mismatches;
  int                                checked;
  // model state: {status2, status1 without its pending bit}
  logic [15:0]                       st;
  logic [11:0]                       act;
  logic [7:0]                        exp_rd;
  logic [7:0]                        exp_r1;
  logic [7:0]                        exp_r2;

  mlsf_top #(.NUM_TACH(4)) u_dut
  (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .monitor_start(monitor_start), .volt_en(volt_en),
    .temp_en(temp_en), .fan_en(fan_en), .volt_upd(volt_upd), .volt_reading(volt_reading),
    .volt_low_limit(volt_low_limit), .volt_high_limit(volt_high_limit),
    .temp_upd(temp_upd), .temp_reading(temp_reading), .temp_low_limit(temp_low_limit),
    .temp_high_limit(temp_high_limit), .tach_upd(tach_upd), .tach_reading(tach_reading),
    .tach_min(tach_min), .diode_fault(diode_fault), .voltage_ident_pins(voltage_ident_pins),
    .remote_one_reading_r(remote_one_reading_r), .remote_two_reading_r(remote_two_reading_r)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // channel to model bit position
  function automatic int pos(input int c);
    return c < 4 ? c : (c == 4 ? 8 : (c < 8 ? c - 1 : c + 2));
  endfunction

  always @(posedge sys_clk or negedge arst_n)
  begin : model
    logic [15:0] n;
    logic [7:0]  rd;
    logic        v;
    logic        up;
    logic        en;
    logic        frc;
    int          t;
    if (!arst_n)
    begin
      st = 16'h0000; act = 12'h000; exp_rd = 8'h00; exp_r1 = 8'h00; exp_r2 = 8'h00;
    end
    else
    begin
      n = st;
      // read returns the latched value; clear-on-read before the set below
      if (reg_rd && reg_addr == `MLSF_OFF_VOLT_TEMP_STATUS)
      begin
        exp_rd = {|st[15:8], st[6:0]};
        for (int c = 0; c < 12; c++) if (pos(c) < 8 && !act[c]) n[pos(c)] = 1'b0;
      end
      if (reg_rd && reg_addr == `MLSF_OFF_FAN_FAULT_STATUS)
      begin
        exp_rd = st[15:8];
        for (int c = 0; c < 12; c++) if (pos(c) >= 8 && !act[c]) n[pos(c)] = 1'b0;
        for (int i = 0; i < 2; i++) if (!diode_fault[i]) n[14+i] = 1'b0;
      end
      if (reg_rd && reg_addr == `MLSF_OFF_VOLTAGE_ID_PINS) exp_rd = {3'b000, voltage_ident_pins};
      for (int c = 0; c < 12; c++)
      begin
        t = c - 5;
        frc = 1'b0;
        if (c < 5)
        begin
          up = volt_upd[c]; en = volt_en[c]; rd = volt_reading[c];
          v = rd <= volt_low_limit[c] || rd > volt_high_limit[c];
        end
        else if (c < 8)
        begin
          frc = t != 1 && diode_fault[t/2];
          up = temp_upd[t] || frc; en = temp_en[t];
          rd = frc ? `MLSF_FORCED_TEMP : temp_reading[t];
          v = $signed(rd) <= $signed(temp_low_limit[t]) || $signed(rd) > $signed(temp_high_limit[t]);
        end
        else
        begin
          up = tach_upd[c-8]; en = fan_en[c-8]; rd = 8'h00;
          v = tach_reading[c-8] > tach_min[c-8];
        end
        if (monitor_start && up)
        begin
          act[c] = v;
          if (!en) n[pos(c)] = 1'b0;
          else if (v) n[pos(c)] = 1'b1;
          if (c == 5) exp_r1 = rd;
          if (c == 7) exp_r2 = rd;
        end
      end
      for (int i = 0; i < 2; i++)
      begin
        if (monitor_start && temp_en[2*i] && diode_fault[i]) n[14+i] = 1'b1;
        // diode enable low drops fault and limit bit at once
        if (!temp_en[2*i])
        begin
          n[14+i] = 1'b0; n[pos(5+2*i)] = 1'b0;
        end
      end
      st = n;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  always @(posedge sys_clk)
  begin
    #1;
    check(reg_rdata_r, exp_rd, "read data");
    check(remote_one_reading_r, exp_r1, "diode one reading");
    check(remote_two_reading_r, exp_r2, "diode two reading");
  end

  // reads get cycles of their own so only fault-forced diode updates race the clear
  task automatic drive(input bit stopped);
    logic [1:0] a;
    reg_rd = ($urandom % 4) == 0;
    a = 2'($urandom);
    reg_addr = a == 2'd3 ? 8'($urandom) : `MLSF_OFF_VOLT_TEMP_STATUS + 8'(a);
    monitor_start = stopped ? 1'b0 : ($urandom % 10) != 0;
    volt_en = ~(5'($urandom) & 5'($urandom) & 5'($urandom));
    temp_en = ~(3'($urandom) & 3'($urandom) & 3'($urandom));
    fan_en = ~(4'($urandom) & 4'($urandom) & 4'($urandom));
    volt_upd = reg_rd ? 5'h00 : 5'($urandom) & 5'($urandom);
    temp_upd = reg_rd ? 3'h0 : 3'($urandom) & 3'($urandom);
    tach_upd = reg_rd ? 4'h0 : 4'($urandom) & 4'($urandom);
    if (($urandom % 20) == 0) diode_fault = 2'($urandom);
    voltage_ident_pins = 5'($urandom);
    for (int i = 0; i < 5; i++)
    begin
      volt_reading[i] = 8'($urandom); volt_low_limit[i] = 8'($urandom % 64);
      volt_high_limit[i] = 8'(192 + $urandom % 64);
    end
    for (int i = 0; i < 3; i++)
    begin
      temp_reading[i] = 8'($urandom); temp_low_limit[i] = 8'(8'hC0 + $urandom % 32);
      temp_high_limit[i] = 8'(32 + $urandom % 64);
    end
    for (int i = 0; i < 4; i++)
    begin
      tach_reading[i] = 16'($urandom); tach_min[i] = 16'($urandom);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #(50 * 20000);
    mismatches++;
    conclude();
  end

  initial
  begin
    arst_n = 1'b0; reg_addr = 8'h00; reg_rd = 1'b0; monitor_start = 1'b0;
    volt_en = '0; temp_en = '0; fan_en = '0; volt_upd = '0; temp_upd = '0; tach_upd = '0;
    volt_reading = '0; volt_low_limit = '0; volt_high_limit = '0; temp_reading = '0;
    temp_low_limit = '0; temp_high_limit = '0; tach_reading = '0; tach_min = '0;
    diode_fault = 2'b00; voltage_ident_pins = '0;
    mismatches = 0; checked = 0;
    void'($urandom(98));
    repeat (10) @(posedge sys_clk);
    #5 arst_n = 1'b1;
    for (int k = 0; k < 6000; k++)
    begin
      @(posedge sys_clk);
      #5;
      // second reset in mid run
      if (k == 3000) arst_n = 1'b0;
      if (k == 3004) arst_n = 1'b1;
      drive(k < 300 || (k >= 3004 && k < 3100));
    end
    conclude();
  end
endmodule // testbench

`default_nettype wire
